// ---- design/pps_cfg.svh ----
// Purpose: Constants for the power state sequencer: offsets, fields, resets, timing.
// Assumes: A 40 MHz system clock.
// Notes:   Included by the package and by the top module; guarded against reinclusion.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PPS_CLK_NS     25
`define PPS_WD_DLY_NS  30000
`define PPS_WD_CYC     ((`PPS_WD_DLY_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS)
`define PPS_PUP_NS     1000
`define PPS_PUP_CYC    ((`PPS_PUP_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS)
`define PPS_PDN_NS     1000
`define PPS_PDN_CYC    ((`PPS_PDN_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS)

// ----------------------------------------------------------------------------
// Self-test
// ----------------------------------------------------------------------------
`define PPS_OSC_WIN    256
`define PPS_OSC_NOM    64
`define PPS_OSC_TOL    15
`define PPS_OSC_LO     (`PPS_OSC_NOM * (100 - `PPS_OSC_TOL) / 100)
`define PPS_OSC_HI     (`PPS_OSC_NOM * (100 + `PPS_OSC_TOL) / 100)
`define PPS_CRC_POLY   8'h07

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define PPS_A_CTRL     8'h00
`define PPS_A_LIMIT    8'h04
`define PPS_A_STATUS   8'h08
`define PPS_A_IRQ      8'h0c
`define PPS_A_MASK     8'h10
`define PPS_A_CRC      8'h14
`define PPS_CTRL_RST   5'h10
`define PPS_LIM_RST    4'h3
`define PPS_MASK_RST   4'h0
`define PPS_CRC_RST    8'h00
`define PPS_ST_CNT_LSB 8
`define PPS_ST_FAIL    16
`define PPS_IRQ_WD     0
`define PPS_IRQ_FLT    1
`define PPS_IRQ_STF    2
`define PPS_IRQ_SON    3

`endif

// ---- design/pps_pkg.sv ----
// Purpose: Types shared by the power state sequencer modules.
// Assumes: pps_cfg.svh holds the numeric constants.
// Notes:   Control fields are listed MSB first.
package pps_pkg;
`include "pps_cfg.svh"

  typedef enum logic [2:0] {
    PPS_DEEP_OFF,
    PPS_SELF_TEST,
    PPS_QUICK_OFF,
    PPS_PWR_UP,
    PPS_SYS_RUN,
    PPS_SYS_STBY,
    PPS_WD_RESET,
    PPS_PWR_DOWN
  } pps_state_e;

  typedef struct packed {
    logic st_variant;
    logic ovlo_disable;
    logic power_button_mode_select;
    logic low_power_off_select;
    logic low_power_input_polarity_invert;
  } pps_ctrl_s;

  typedef struct packed {
    logic done;
    logic fail;
    logic osc_fail;
    logic crc_fail;
    logic mon_fail;
  } pps_st_res_s;

endpackage

// ---- design/pps_self_test.sv ----
// Purpose: Self-test engine: oscillator tolerance, mirror CRC and monitor test.
// Assumes: osc_tick and mon_ok are already synchronised to clock.
// Notes:   One run lasts a fixed window; done pulses one cycle after it.
module pps_self_test
  import pps_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic        osc_tick,
  input  wire logic        mon_ok,
  input  wire logic [31:0] mirror,
  input  wire logic [7:0]  crc_ref,
  output logic             mon_req,
  output pps_st_res_s      res
);

  logic [8:0] win;
  logic       tick_d;
  logic [7:0] ticks;
  logic [7:0] crc;
  logic [7:0] next_crc;
  logic       mon_bad;
  logic       last;
  logic       osc_bad;
  logic       crc_bad;

  assign last    = mon_req && (win == 9'(`PPS_OSC_WIN - 1));
  assign osc_bad = (ticks < 8'(`PPS_OSC_LO)) || (ticks > 8'(`PPS_OSC_HI));
  assign crc_bad = crc != crc_ref;

  always_comb begin
    next_crc = {crc[6:0], 1'b0};
    if (crc[7] ^ mirror[5'd31 - win[4:0]]) begin
      next_crc = next_crc ^ `PPS_CRC_POLY;
    end
  end

  // The monitor test request stays high for the whole window.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mon_req <= 1'b0;
      win     <= 9'h000;
    end else if (start) begin
      mon_req <= 1'b1;
      win     <= 9'h000;
    end else if (mon_req) begin
      mon_req <= !last;
      win     <= win + 9'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tick_d  <= 1'b0;
      ticks   <= 8'h00;
      crc     <= 8'h00;
      mon_bad <= 1'b0;
    end else begin
      tick_d <= osc_tick;
      if (start) begin
        ticks   <= 8'h00;
        crc     <= 8'h00;
        mon_bad <= 1'b0;
      end else if (mon_req) begin
        if (osc_tick && !tick_d && ticks != 8'hff) begin
          ticks <= ticks + 8'h01;
        end
        if (win < 9'h020) begin
          crc <= next_crc;
        end
        if (!mon_ok) begin
          mon_bad <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      res <= '0;
    end else begin
      res.done <= last;
      if (last) begin
        res.osc_fail <= osc_bad;
        res.crc_fail <= crc_bad;
        res.mon_fail <= mon_bad || !mon_ok;
        res.fail     <= osc_bad || crc_bad || mon_bad || !mon_ok;
      end
    end
  end

  AST_OSC_TOL: assert property (@(posedge clock) disable iff (!rst_b)
    last && osc_bad |=> res.done && res.fail && res.osc_fail)
    else $error("oscillator out of tolerance not flagged");

  AST_CRC_CHK: assert property (@(posedge clock) disable iff (!rst_b)
    last && crc_bad |=> res.fail && res.crc_fail)
    else $error("mirror CRC mismatch not flagged");

  AST_MON_TEST: assert property (@(posedge clock) disable iff (!rst_b)
    last && (mon_bad || !mon_ok) |=> res.done && res.fail && res.mon_fail)
    else $error("monitor test failure not flagged");

endmodule

// ---- design/pps_power_state_machine.sv ----
// Purpose: Power state sequencer: off exits, self-test, run/standby, watchdog reset.
// Assumes: 40 MHz CLOCK, synchronous active-low RST_B, APB register access.
// Notes:   Pin inputs pass two flip-flops before use.
module pps_power_state_machine
  import pps_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        STANDBY_IN,
  input  wire logic        POWER_ON_INPUT,
  input  wire logic        TEST_BOARD_MODE_ENABLE,
  input  wire logic        VIN_ABOVE_UV,
  input  wire logic        VIN_BELOW_OVLO,
  input  wire logic        TJ_BELOW_SHUTDOWN,
  input  wire logic        TRIM_LOAD_ERROR,
  input  wire logic        FUSE_LOAD_ERROR,
  input  wire logic        HARD_WD_RESET,
  input  wire logic        OSC_TICK,
  input  wire logic        MONITOR_TEST_OK,
  output logic             MONITOR_TEST_REQ,
  output logic             PROCESSOR_RESET_OUTPUT_B,
  output logic [2:0]       STATE_CODE,
  output logic             IRQ
);
`include "pps_cfg.svh"

  localparam int NPIN = 11;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;

  assign pin_raw = {MONITOR_TEST_OK, OSC_TICK, HARD_WD_RESET, FUSE_LOAD_ERROR,
                    TRIM_LOAD_ERROR, TJ_BELOW_SHUTDOWN, VIN_BELOW_OVLO, VIN_ABOVE_UV,
                    TEST_BOARD_MODE_ENABLE, POWER_ON_INPUT, STANDBY_IN};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
      end else begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
      end
    end
  end

  logic stby_pin;
  logic pon;
  logic tbb;
  logic wd_pin;
  logic osc_tick_s;
  logic mon_ok_s;
  logic pon_d;
  logic wd_d;

  assign stby_pin   = pin_s2[0];
  assign pon        = pin_s2[1];
  assign tbb        = pin_s2[2];
  assign wd_pin     = pin_s2[8];
  assign osc_tick_s = pin_s2[9];
  assign mon_ok_s   = pin_s2[10];

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      pon_d <= 1'b0;
      wd_d  <= 1'b0;
    end else begin
      pon_d <= pon;
      wd_d  <= wd_pin;
    end
  end

  // --------------------------------------------------------------------------
  // Registers and derived conditions
  // --------------------------------------------------------------------------
  pps_ctrl_s   ctrl;
  logic [3:0]  wd_limit;
  logic [3:0]  irq_mask;
  logic [3:0]  irq_stat;
  logic [7:0]  crc_ref;
  pps_state_e  state;
  pps_state_e  next_state;
  logic [10:0] timer;
  logic [3:0]  wd_cnt;
  logic        st_fail;
  logic        up_pend;
  logic        st_start;
  pps_st_res_s st_res;
  logic        pon_fall;
  logic        wd_evt;
  logic        pwr_ok;
  logic        pwr_evt;
  logic        lpm;
  logic        stby_req;
  logic        direct_evt;

  assign pon_fall = pon_d && !pon;
  assign wd_evt   = wd_pin && !wd_d;
  assign lpm      = ctrl.low_power_off_select;
  assign pwr_ok   = pin_s2[3] && (pin_s2[4] || ctrl.ovlo_disable) && pin_s2[5]
                    && !pin_s2[6] && !pin_s2[7];
  assign pwr_evt  = ctrl.power_button_mode_select ? pon_fall : pon;
  assign stby_req = stby_pin ^ ctrl.low_power_input_polarity_invert;
  assign direct_evt = !tbb && !lpm && pwr_evt && pwr_ok;
  assign st_start = (state != PPS_SELF_TEST) && (next_state == PPS_SELF_TEST);

  // --------------------------------------------------------------------------
  // State transitions
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      PPS_DEEP_OFF: begin
        if (tbb || (lpm && !st_fail) || direct_evt) begin
          next_state = ctrl.st_variant ? PPS_SELF_TEST : PPS_QUICK_OFF;
        end
      end
      PPS_SELF_TEST: begin
        if (tbb || (st_res.done && !st_res.fail)) begin
          next_state = PPS_QUICK_OFF;
        end else if (st_res.done) begin
          next_state = PPS_DEEP_OFF;
        end
      end
      PPS_QUICK_OFF: begin
        if (!st_fail && (up_pend || (pwr_evt && pwr_ok))) begin
          next_state = PPS_PWR_UP;
        end
      end
      PPS_PWR_UP: begin
        if (timer == 11'(`PPS_PUP_CYC - 1)) begin
          next_state = PPS_SYS_RUN;
        end
      end
      PPS_SYS_RUN: begin
        if (wd_evt) begin
          next_state = PPS_WD_RESET;
        end else if (stby_req) begin
          next_state = PPS_SYS_STBY;
        end
      end
      PPS_SYS_STBY: begin
        if (wd_evt) begin
          next_state = PPS_WD_RESET;
        end else if (!stby_req) begin
          next_state = PPS_SYS_RUN;
        end
      end
      PPS_WD_RESET: begin
        if (wd_cnt >= wd_limit) begin
          next_state = PPS_PWR_DOWN;
        end else if (timer == 11'(`PPS_WD_CYC - 1)) begin
          next_state = PPS_SYS_RUN;
        end
      end
      PPS_PWR_DOWN: begin
        if (timer == 11'(`PPS_PDN_CYC - 1)) begin
          next_state = PPS_DEEP_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state <= PPS_DEEP_OFF;
    end else begin
      state <= next_state;
    end
  end

  assign STATE_CODE = state;

  always_ff @(posedge CLOCK) begin
    if (!RST_B || state != next_state) begin
      timer <= 11'h000;
    end else if (timer != 11'h7ff) begin
      timer <= timer + 11'h001;
    end
  end

  // The count survives watchdog returns and clears only after a power-down.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      wd_cnt <= 4'h0;
    end else if (next_state == PPS_WD_RESET && state != PPS_WD_RESET) begin
      if (wd_cnt != 4'hf) begin
        wd_cnt <= wd_cnt + 4'h1;
      end
    end else if (state == PPS_PWR_DOWN && next_state == PPS_DEEP_OFF) begin
      wd_cnt <= 4'h0;
    end
  end

  // A power-up event seen in deep off is remembered across self-test.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      up_pend <= 1'b0;
    end else if (state == PPS_DEEP_OFF && next_state != PPS_DEEP_OFF) begin
      up_pend <= direct_evt;
    end else if (next_state == PPS_PWR_UP || next_state == PPS_DEEP_OFF) begin
      up_pend <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      st_fail <= 1'b0;
    end else if (state == PPS_SELF_TEST) begin
      if (tbb) begin
        st_fail <= 1'b0;
      end else if (st_res.done) begin
        st_fail <= st_res.fail;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PROCESSOR_RESET_OUTPUT_B <= 1'b0;
    end else begin
      PROCESSOR_RESET_OUTPUT_B <= (next_state == PPS_SYS_RUN)
                                  || (next_state == PPS_SYS_STBY);
    end
  end

  pps_self_test u_self_test (
    .clock   (CLOCK),
    .rst_b   (RST_B),
    .start   (st_start),
    .osc_tick(osc_tick_s),
    .mon_ok  (mon_ok_s),
    .mirror  ({23'h00_0000, wd_limit, ctrl}),
    .crc_ref (crc_ref),
    .mon_req (MONITOR_TEST_REQ),
    .res     (st_res)
  );

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic       bus_done;

  assign bus_done = PSEL && PENABLE && PREADY;
  assign irq_set[`PPS_IRQ_WD]  = next_state == PPS_WD_RESET && state != PPS_WD_RESET;
  assign irq_set[`PPS_IRQ_FLT] = next_state == PPS_PWR_DOWN && state == PPS_WD_RESET;
  assign irq_set[`PPS_IRQ_STF] = state == PPS_SELF_TEST && !tbb && st_res.done
                                 && st_res.fail;
  assign irq_set[`PPS_IRQ_SON] = state == PPS_PWR_UP && next_state == PPS_SYS_RUN;
  assign irq_clr = (bus_done && !PWRITE && PADDR == `PPS_A_IRQ) ? PRDATA[3:0] : 4'h0;

  // Only the bits that the read returned are cleared; a new event wins.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      irq_stat <= 4'h0;
      IRQ      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      IRQ      <= |(irq_stat & irq_mask);
    end
  end

  // --------------------------------------------------------------------------
  // APB slave: one wait state, data and error captured with PREADY
  // --------------------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_hit;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (PADDR)
      `PPS_A_CTRL:   rd_data[4:0] = ctrl;
      `PPS_A_LIMIT:  rd_data[3:0] = wd_limit;
      `PPS_A_STATUS: begin
        rd_data[2:0] = state;
        rd_data[`PPS_ST_CNT_LSB +: 4] = wd_cnt;
        rd_data[`PPS_ST_FAIL] = st_fail;
      end
      `PPS_A_IRQ:    rd_data[3:0] = irq_stat;
      `PPS_A_MASK:   rd_data[3:0] = irq_mask;
      `PPS_A_CRC:    rd_data[7:0] = crc_ref;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !rd_hit;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_data;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ctrl     <= `PPS_CTRL_RST;
      wd_limit <= `PPS_LIM_RST;
      irq_mask <= `PPS_MASK_RST;
      crc_ref  <= `PPS_CRC_RST;
    end else if (bus_done && PWRITE) begin
      case (PADDR)
        `PPS_A_CTRL:  ctrl     <= PWDATA[4:0];
        `PPS_A_LIMIT: wd_limit <= PWDATA[3:0];
        `PPS_A_MASK:  irq_mask <= PWDATA[3:0];
        `PPS_A_CRC:   crc_ref  <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  AST_STBY_TO_RUN: assert property (
    state == PPS_SYS_STBY && !wd_evt && !(stby_pin ^ ctrl.low_power_input_polarity_invert)
    |=> state == PPS_SYS_RUN) else $error("standby did not return to run");

  AST_RUN_TO_STBY: assert property (
    state == PPS_SYS_RUN && !wd_evt && (stby_pin != ctrl.low_power_input_polarity_invert)
    |=> state == PPS_SYS_STBY) else $error("run did not enter standby");

  AST_WD_ENTER: assert property (
    (state == PPS_SYS_RUN || state == PPS_SYS_STBY) && wd_pin && !wd_d
    |=> state == PPS_WD_RESET ##1 !PROCESSOR_RESET_OUTPUT_B)
    else $error("watchdog event ignored");

  AST_WD_HOLD: assert property (
    state == PPS_WD_RESET && wd_cnt < wd_limit && timer < 11'(`PPS_WD_CYC - 1)
    |=> state == PPS_WD_RESET) else $error("watchdog reset left early");

  AST_WD_BACK: assert property (
    state == PPS_WD_RESET && wd_cnt < wd_limit && timer == 11'(`PPS_WD_CYC - 1)
    |=> state == PPS_SYS_RUN) else $error("watchdog reset did not return");

  AST_WD_FAULT: assert property (
    state == PPS_WD_RESET && wd_cnt == wd_limit |=> state == PPS_PWR_DOWN ##1 irq_stat[1])
    else $error("watchdog limit did not power down");

  AST_OFF_TRANSIT: assert property (
    state == PPS_DEEP_OFF && ctrl.st_variant && lpm && !tbb && !st_fail
    |=> state == PPS_SELF_TEST ##1 MONITOR_TEST_REQ) else $error("no transit to self-test");

  AST_LEVEL_UP: assert property (
    state == PPS_DEEP_OFF && !lpm && !tbb && !ctrl.power_button_mode_select && pon && pwr_ok
    |=> state != PPS_DEEP_OFF) else $error("level power-on ignored");

  AST_EDGE_ONLY: assert property (
    state == PPS_DEEP_OFF && !lpm && !tbb && ctrl.power_button_mode_select && !pon_fall
    |=> state == PPS_DEEP_OFF) else $error("edge mode left off without an edge");

  AST_TBB_PATH: assert property (
    state == PPS_DEEP_OFF && tbb && ctrl.st_variant ##1 tbb
    |=> state == PPS_QUICK_OFF) else $error("test-board path missing");

  AST_ST_EXIT: assert property (
    state == PPS_SELF_TEST && st_res.done && !st_res.fail |=> state == PPS_QUICK_OFF)
    else $error("passed self-test did not advance");

  AST_NO_ST: assert property (
    state == PPS_DEEP_OFF && !ctrl.st_variant && next_state != PPS_DEEP_OFF
    |=> state == PPS_QUICK_OFF) else $error("direct off exit went elsewhere");

  AST_FAIL_BLOCK: assert property (
    state == PPS_QUICK_OFF && st_fail |=> state != PPS_PWR_UP)
    else $error("power-up despite self-test failure");

  AST_RST_REL: assert property (
    $rose(PROCESSOR_RESET_OUTPUT_B)
    |-> state == PPS_SYS_RUN && ($past(state) == PPS_PWR_UP || $past(state) == PPS_WD_RESET))
    else $error("processor reset released out of sequence");

  AST_WD_COUNT: assert property (
    $rose(state == PPS_WD_RESET) && $past(wd_cnt) != 4'hf |-> wd_cnt == $past(wd_cnt) + 4'h1)
    else $error("watchdog count not incremented");

  COV_SYS_ON: cover property ($rose(state == PPS_SYS_RUN) && $past(state) == PPS_PWR_UP);
  COV_STBY:   cover property (state == PPS_SYS_RUN ##1 state == PPS_SYS_STBY);
  COV_FAULT:  cover property (state == PPS_WD_RESET ##1 state == PPS_PWR_DOWN);
  COV_TBB:    cover property (state == PPS_SELF_TEST && tbb ##1 state == PPS_QUICK_OFF);

endmodule

// ---- tb/pps_far_side.sv ----
// Purpose: Far-side model: fast oscillator divider and monitor test answer.
// Assumes: Four clock cycles per oscillator period, 64 edges per window.
// Notes:   mon_bad makes the monitor test answer fail.
module pps_far_side (
  input  wire logic clock,
  input  wire logic mon_req,
  input  wire logic mon_bad,
  output logic      osc_tick,
  output logic      mon_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div = 2'h0;
  always @(posedge clock) begin
    div <= div + 2'h1;
  end
  assign osc_tick = div[1];
  // Outside a request the answer line toggles, so it carries no stale pass.
  assign mon_ok = mon_req ? !mon_bad : div[0];
endmodule

// ---- tb/test_pps_power_state_machine.sv ----
// Purpose: Bench for the power state sequencer over APB and pins.
// Assumes: Load errors absent; supplies good except one undervoltage step.
// Notes:   State changes are polled with bounded waits.
module test_pps_power_state_machine
  import pps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLOCK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r;
  logic        PREADY, PSLVERR, IRQ, OSC_TICK, MONITOR_TEST_OK, MONITOR_TEST_REQ;
  logic        STANDBY_IN = 0, POWER_ON_INPUT = 0, TEST_BOARD_MODE_ENABLE = 0;
  logic        HARD_WD_RESET = 0, mon_bad = 0, e, PROCESSOR_RESET_OUTPUT_B, VIN_ABOVE_UV = 1;
  logic [2:0]  STATE_CODE;
  int          n, n_mismatch = 0, samples_checked = 0;
  always #12.5 CLOCK = ~CLOCK;
  pps_power_state_machine DUT (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STANDBY_IN(STANDBY_IN),
    .POWER_ON_INPUT(POWER_ON_INPUT), .TEST_BOARD_MODE_ENABLE(TEST_BOARD_MODE_ENABLE),
    .VIN_ABOVE_UV(VIN_ABOVE_UV), .VIN_BELOW_OVLO(1'h1), .TJ_BELOW_SHUTDOWN(1'h1),
    .TRIM_LOAD_ERROR(1'h0), .FUSE_LOAD_ERROR(1'h0), .HARD_WD_RESET(HARD_WD_RESET),
    .OSC_TICK(OSC_TICK), .MONITOR_TEST_OK(MONITOR_TEST_OK),
    .MONITOR_TEST_REQ(MONITOR_TEST_REQ), .STATE_CODE(STATE_CODE), .IRQ(IRQ),
    .PROCESSOR_RESET_OUTPUT_B(PROCESSOR_RESET_OUTPUT_B));
  pps_far_side far (.clock(CLOCK), .mon_req(MONITOR_TEST_REQ), .mon_bad(mon_bad),
    .osc_tick(OSC_TICK), .mon_ok(MONITOR_TEST_OK));
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1;
    do @(posedge CLOCK); while (PREADY !== 1'h1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task ws(input logic [2:0] s, input int m);
    n = 0;
    while (STATE_CODE !== s && n < m) begin
      @(posedge CLOCK);
      n++;
    end
    chk(STATE_CODE, s);
  endtask
  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_B <= 1;
    chk(PROCESSOR_RESET_OUTPUT_B, 0);
    apb(0, 8'h00, 0);
    chk(r, 32'h0000_0010);
    apb(0, 8'h04, 0);
    chk(r, 32'h0000_0003);
    apb(0, 8'h20, 0);
    chk(e, 1);
    apb(1, 8'h10, 32'h0000_0008);
    TEST_BOARD_MODE_ENABLE <= 1;
    POWER_ON_INPUT <= 1;
    ws(1, 10);
    ws(2, 10);
    chk(MONITOR_TEST_REQ, 1);
    ws(4, 100);
    chk(PROCESSOR_RESET_OUTPUT_B, 1);
    repeat (2) @(posedge CLOCK);
    chk(IRQ, 1);
    apb(0, 8'h0c, 0);
    chk(r & 32'h0000_0008, 32'h0000_0008);
    repeat (2) @(posedge CLOCK);
    chk(IRQ, 0);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) apb(1, 8'h00, 32'h0000_0011);
      STANDBY_IN <= (i[0] == 0) ^ (i > 1);
      ws(i[0] ? 3'h4 : 3'h5, 10);
    end
    apb(1, 8'h04, 32'h0000_0002);
    for (int k = 1; k < 3; k++) begin
      HARD_WD_RESET <= 1;
      repeat (4) @(posedge CLOCK);
      HARD_WD_RESET <= 0;
      ws(6, 10);
      apb(0, 8'h08, 0);
      chk(r[11:8], 32'(k));
      if (k == 1) begin
        ws(4, 1300);
        chk(n > 1180 && n < 1205, 1);
      end
      else ws(7, 10);
    end
    TEST_BOARD_MODE_ENABLE <= 0;
    mon_bad <= 1;
    ws(0, 100);
    apb(0, 8'h0c, 0);
    chk(r & 32'h0000_0003, 32'h0000_0003);
    ws(1, 400);
    ws(0, 400);
    apb(0, 8'h08, 0);
    chk(r[16], 1);
    POWER_ON_INPUT <= 0;
    ws(0, 400);
    apb(1, 8'h00, 32'h0000_0004);
    for (int j = 0; j < 4; j++) begin
      POWER_ON_INPUT <= !j[0];
      VIN_ABOVE_UV <= j > 1;
      if (j < 3) begin
        repeat (8) @(posedge CLOCK);
        chk(STATE_CODE, 0);
      end
    end
    ws(2, 10);
    repeat (8) @(posedge CLOCK);
    chk(STATE_CODE, 2);
    end_sim;
  end
endmodule
